/* File: sgp_status_ctrl.sv */
// sgp_status_ctrl.sv: receiver non-audio handling, pin source selectors and
// powerdown control bank, reached through the device register port.
// assumes status inputs and the register port run on core_clk; pin inputs are asynchronous.
`include "sgp_defines.svh"

module sgp_status_ctrl
  import sgp_pkg::*;
#(
  parameter int HOLD_WORDS = `SGP_PCM_HOLD_WORDS,
  parameter int NUM_PINS = 7
) (
  input wire logic core_clk,
  input wire logic arst_n,
  // register port
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [6:0] reg_addr,
  input wire logic [8:0] reg_wdata,
  output logic [8:0] reg_rdata,
  output logic reg_rvalid,
  // receiver status and data
  input wire logic rx_word_valid,
  input wire logic [15:0] rx_word,
  input wire logic rx_validity,
  input wire logic rx_user,
  input wire logic rx_channel,
  input wire logic rx_parity,
  input wire logic subframe_indicator,
  input wire logic block_start_indicator,
  input wire logic rx_unlock,
  input wire logic chan_status_update,
  input wire logic rate_is_top_flag,
  input wire logic zero_detect_flag,
  input wire logic rx_audio_n,
  input wire logic copy_assert_low,
  input wire logic emphasis_flag,
  input wire logic first_stereo_dac_from_rx,
  input wire logic irq_other_n,
  input wire logic irq_ack,
  // status flags and events
  output logic rx_pcm_n,
  output logic nonaudio_change_event,
  output logic interrupt_out_low,
  output logic first_stereo_dac_softmute,
  output logic fill_zero_mode,
  output logic ignore_invalid,
  // general-purpose pins
  input wire logic [NUM_PINS-1:0] gpo_pin_in,
  output logic [NUM_PINS-1:0] gpo_pin_out,
  output logic [NUM_PINS-1:0] gpo_pin_oe,
  output logic [2:0] rx_cmos_in_sel,
  output logic [2:0] rx_comp_in_sel,
  output logic [2:0] rx_pin_data,
  // powerdown controls, one means off
  output logic adc_off,
  output logic [2:0] dac_off,
  output logic link_tx_off,
  output logic link_rx_off,
  output logic clock_recovery_off,
  output logic first_pll_off,
  output logic second_pll_off,
  output logic oscillator_off,
  output logic osc_ext_clk_mode,
  output logic references_off,
  output logic outputs_muted
);

  if (NUM_PINS != 7) begin : g_bad_pins
    $error("sgp_status_ctrl: the selector map serves exactly seven pins");
  end

  // register file
  sgp_reg_t int_mask_r;
  sgp_reg_t gpo_12_r;
  sgp_reg_t gpo_34_r;
  sgp_reg_t gpo_56_r;
  sgp_reg_t gpo_7_r;
  sgp_reg_t pwr_conv_r;
  sgp_reg_t pwr_clk_r;
  sgp_reg_t rdata_nxt;
  logic hit_mask, hit_g12, hit_g34, hit_g56, hit_g7, hit_pc, hit_pk;

  // address decode
  assign hit_mask = (reg_addr == `SGP_OFS_INT_MASK);
  assign hit_g12 = (reg_addr == `SGP_OFS_GPO_12);
  assign hit_g34 = (reg_addr == `SGP_OFS_GPO_34);
  assign hit_g56 = (reg_addr == `SGP_OFS_GPO_56);
  assign hit_g7 = (reg_addr == `SGP_OFS_GPO_7);
  assign hit_pc = (reg_addr == `SGP_OFS_PWR_CONV);
  assign hit_pk = (reg_addr == `SGP_OFS_PWR_CLK);

  // writes keep only the defined bits, so reserved bits always read zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      int_mask_r <= `SGP_RST_INT_MASK;
      gpo_12_r <= `SGP_RST_GPO_12;
      gpo_34_r <= `SGP_RST_GPO_34;
      gpo_56_r <= `SGP_RST_GPO_56;
      gpo_7_r <= `SGP_RST_GPO_7;
      pwr_conv_r <= `SGP_RST_PWR_CONV;
      pwr_clk_r <= `SGP_RST_PWR_CLK;
    end else if (reg_wr_en) begin
      if (hit_mask) int_mask_r <= reg_wdata & `SGP_WMASK_INT_MASK;
      if (hit_g12) gpo_12_r <= reg_wdata & `SGP_WMASK_GPO_FULL;
      if (hit_g34) gpo_34_r <= reg_wdata & `SGP_WMASK_GPO_FULL;
      if (hit_g56) gpo_56_r <= reg_wdata & `SGP_WMASK_GPO_56;
      if (hit_g7) gpo_7_r <= reg_wdata & `SGP_WMASK_GPO_7;
      if (hit_pc) pwr_conv_r <= reg_wdata & `SGP_WMASK_PWR_CONV;
      if (hit_pk) pwr_clk_r <= reg_wdata & `SGP_WMASK_PWR_CLK;
    end
  end

  // read mux; unmapped addresses read zero
  assign rdata_nxt = hit_mask ? int_mask_r :
                     hit_g12 ? gpo_12_r :
                     hit_g34 ? gpo_34_r :
                     hit_g56 ? gpo_56_r :
                     hit_g7 ? gpo_7_r :
                     hit_pc ? pwr_conv_r :
                     hit_pk ? pwr_clk_r : 9'h000;

  // read data held until the next read
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 9'h000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd_en;
      if (reg_rd_en) reg_rdata <= rdata_nxt;
    end
  end

  // non-pcm sync search
  sgp_rx_if rx_if ();
  logic master_off;
  logic rx_path_off;

  assign rx_if.word_valid = rx_word_valid;
  assign rx_if.word = rx_word;
  // a receiver that is off or unlocked delivers no trustworthy burst
  assign rx_if.clear = rx_path_off | rx_unlock;

  sgp_nonpcm_detect #(
    .HOLD_WORDS(HOLD_WORDS)
  ) u_detect (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .rx(rx_if.det)
  );

  // non-audio change events and mute
  logic audio_n_prev_r;
  logic pcm_n_prev_r;
  logic pend_r;
  logic audio_n_chg;
  logic pcm_n_chg;
  logic event_nxt;
  logic non_audio;

  assign non_audio = rx_audio_n | rx_if.pcm_n;
  assign audio_n_chg = (rx_audio_n != audio_n_prev_r) && !int_mask_r[`SGP_MASK_BIT_AUDIO_N];
  assign pcm_n_chg = (rx_if.pcm_n != pcm_n_prev_r) && !int_mask_r[`SGP_MASK_BIT_PCM_N];
  assign event_nxt = audio_n_chg | pcm_n_chg;

  // event pulse, pending level for the interrupt pin; a new event beats an ack
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      audio_n_prev_r <= 1'b0;
      pcm_n_prev_r <= 1'b0;
      pend_r <= 1'b0;
      nonaudio_change_event <= 1'b0;
      interrupt_out_low <= 1'b1;
      rx_pcm_n <= 1'b0;
      first_stereo_dac_softmute <= 1'b0;
    end else begin
      audio_n_prev_r <= rx_audio_n;
      pcm_n_prev_r <= rx_if.pcm_n;
      nonaudio_change_event <= event_nxt;
      pend_r <= event_nxt | (pend_r & ~irq_ack);
      interrupt_out_low <= irq_other_n & ~(event_nxt | (pend_r & ~irq_ack));
      rx_pcm_n <= rx_if.pcm_n;
      // mask bits never touch the mute path
      first_stereo_dac_softmute <= first_stereo_dac_from_rx & non_audio;
    end
  end

  // status sources, indexed by selector code
  logic [13:0] src_vec;
  logic [3:0] sel [NUM_PINS];

  assign src_vec = {emphasis_flag, copy_assert_low, non_audio, zero_detect_flag,
                    rate_is_top_flag, chan_status_update, rx_unlock, block_start_indicator,
                    subframe_indicator, rx_parity, rx_channel, rx_user, rx_validity,
                    interrupt_out_low};
  assign sel[0] = gpo_12_r[`SGP_SEL_LO_LSB +: 4];
  assign sel[1] = gpo_12_r[`SGP_SEL_HI_LSB +: 4];
  assign sel[2] = gpo_34_r[`SGP_SEL_LO_LSB +: 4];
  assign sel[3] = gpo_34_r[`SGP_SEL_HI_LSB +: 4];
  assign sel[4] = gpo_56_r[`SGP_SEL_LO_LSB +: 4];
  assign sel[5] = gpo_56_r[`SGP_SEL_HI_LSB +: 4];
  assign sel[6] = gpo_7_r[`SGP_SEL_LO_LSB +: 4];
  assign fill_zero_mode = gpo_12_r[`SGP_BIT_FILL_ZERO];
  assign ignore_invalid = gpo_34_r[`SGP_BIT_IGNORE_INVALID];

  // per pin: drive the selected source, or release the pin as a receiver input.
  // receiver-input codes on pins without an input path drive the pin low instead.
  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    localparam bit CAN_RX = (p >= 2) && (p <= 4);
    logic is_rx_code;
    logic rx_mode;
    logic out_nxt;

    assign is_rx_code = (sel[p] == SGP_SRC_RX_CMOS) || (sel[p] == SGP_SRC_RX_COMPARATOR);
    assign rx_mode = CAN_RX && is_rx_code;
    assign out_nxt = is_rx_code ? 1'b0 : src_vec[sel[p]];

    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        gpo_pin_out[p] <= 1'b0;
        gpo_pin_oe[p] <= 1'b0;
      end else begin
        gpo_pin_out[p] <= out_nxt;
        gpo_pin_oe[p] <= ~rx_mode;
      end
    end
  end

  // receiver inputs on pins three to five: two-stage sync, then a staging flop
  for (genvar k = 0; k < 3; k++) begin : g_rx_in
    logic meta_r;
    logic sync_r;

    always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
        meta_r <= 1'b0;
        sync_r <= 1'b0;
        rx_pin_data[k] <= 1'b0;
        rx_cmos_in_sel[k] <= 1'b0;
        rx_comp_in_sel[k] <= 1'b0;
      end else begin
        meta_r <= gpo_pin_in[k+2];
        sync_r <= meta_r;
        rx_pin_data[k] <= sync_r;
        rx_cmos_in_sel[k] <= (sel[k+2] == SGP_SRC_RX_CMOS);
        rx_comp_in_sel[k] <= (sel[k+2] == SGP_SRC_RX_COMPARATOR);
      end
    end
  end

  // effective powerdown: master overrides every other bit
  logic dac_all;

  assign master_off = pwr_conv_r[`SGP_BIT_MASTER_OFF];
  assign dac_all = master_off | pwr_conv_r[`SGP_BIT_ALL_DACS_OFF];
  assign rx_path_off = master_off | pwr_clk_r[`SGP_BIT_LINK_RX_OFF];

  // registered controls; the advised ordering of converter and master bits is
  // left to software, and no hazard arises here if it is skipped
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      adc_off <= 1'b1;
      dac_off <= 3'h7;
      link_tx_off <= 1'b1;
      link_rx_off <= 1'b1;
      clock_recovery_off <= 1'b1;
      first_pll_off <= 1'b1;
      second_pll_off <= 1'b1;
      oscillator_off <= 1'b0;
      osc_ext_clk_mode <= 1'b0;
      references_off <= 1'b0;
      outputs_muted <= 1'b0;
    end else begin
      adc_off <= master_off | pwr_conv_r[`SGP_BIT_ADC_OFF];
      dac_off <= {3{dac_all}} | pwr_conv_r[`SGP_DAC_OFF_LSB +: 3];
      link_tx_off <= master_off | pwr_clk_r[`SGP_BIT_LINK_TX_OFF];
      link_rx_off <= rx_path_off;
      first_pll_off <= master_off | pwr_clk_r[`SGP_BIT_PLL1_OFF];
      second_pll_off <= master_off | pwr_clk_r[`SGP_BIT_PLL2_OFF];
      clock_recovery_off <= master_off | pwr_clk_r[`SGP_BIT_RECOVERY_OFF];
      oscillator_off <= master_off | pwr_clk_r[`SGP_BIT_OSC_OFF];
      osc_ext_clk_mode <= master_off | pwr_clk_r[`SGP_BIT_OSC_OFF];
      references_off <= master_off;
      outputs_muted <= master_off;
    end
  end

endmodule : sgp_status_ctrl

/* File: sgp_defines.svh */
// sgp_defines.svh: register offsets, field positions, reset values and counts
// for the receiver status, pin selector and powerdown control block.
// assumes inclusion by bare name from the block's package and modules.
`ifndef SGP_DEFINES_SVH
`define SGP_DEFINES_SVH

// register offsets on the control port (7-bit register index)
`define SGP_OFS_INT_MASK 7'h25
`define SGP_OFS_GPO_12 7'h26
`define SGP_OFS_GPO_34 7'h27
`define SGP_OFS_GPO_56 7'h28
`define SGP_OFS_GPO_7 7'h29
`define SGP_OFS_PWR_CONV 7'h32
`define SGP_OFS_PWR_CLK 7'h33

// writable bits of each register, the rest read as zero
`define SGP_WMASK_INT_MASK 9'h1FF
`define SGP_WMASK_GPO_FULL 9'h1FF
`define SGP_WMASK_GPO_56 9'h0FF
`define SGP_WMASK_GPO_7 9'h00F
`define SGP_WMASK_PWR_CONV 9'h05F
`define SGP_WMASK_PWR_CLK 9'h03F

// reset values
`define SGP_RST_INT_MASK 9'h000
`define SGP_RST_GPO_12 9'h010
`define SGP_RST_GPO_34 9'h032
`define SGP_RST_GPO_56 9'h054
`define SGP_RST_GPO_7 9'h006
`define SGP_RST_PWR_CONV 9'h05E
`define SGP_RST_PWR_CLK 9'h03E

// field positions
`define SGP_SEL_LO_LSB 0
`define SGP_SEL_HI_LSB 4
`define SGP_BIT_FILL_ZERO 8
`define SGP_BIT_IGNORE_INVALID 8
`define SGP_MASK_BIT_AUDIO_N 4
`define SGP_MASK_BIT_PCM_N 5
`define SGP_BIT_MASTER_OFF 0
`define SGP_BIT_ADC_OFF 1
`define SGP_DAC_OFF_LSB 2
`define SGP_BIT_ALL_DACS_OFF 6
`define SGP_BIT_OSC_OFF 0
`define SGP_BIT_PLL1_OFF 1
`define SGP_BIT_PLL2_OFF 2
`define SGP_BIT_RECOVERY_OFF 3
`define SGP_BIT_LINK_TX_OFF 4
`define SGP_BIT_LINK_RX_OFF 5

// non-audio sync search: six 16-bit words, and words without a match before release
`define SGP_SYNC_CODE 96'h0000_0000_0000_0000_F872_4E1F
`define SGP_PCM_HOLD_WORDS 4096

`endif

/* File: sgp_pkg.sv */
// sgp_pkg.sv: types shared by the receiver status and powerdown control block.
// assumes sgp_defines.svh is on the include path.
`include "sgp_defines.svh"

package sgp_pkg;

  // pin source selector codes, in routing order
  typedef enum logic [3:0] {
    SGP_SRC_INTERRUPT = 4'h0,
    SGP_SRC_VALIDITY = 4'h1,
    SGP_SRC_USER = 4'h2,
    SGP_SRC_CHANNEL = 4'h3,
    SGP_SRC_PARITY = 4'h4,
    SGP_SRC_SUBFRAME = 4'h5,
    SGP_SRC_BLOCK_START = 4'h6,
    SGP_SRC_UNLOCK = 4'h7,
    SGP_SRC_CS_UPDATE = 4'h8,
    SGP_SRC_RATE_TOP = 4'h9,
    SGP_SRC_ZERO = 4'hA,
    SGP_SRC_NON_AUDIO = 4'hB,
    SGP_SRC_COPY = 4'hC,
    SGP_SRC_EMPHASIS = 4'hD,
    SGP_SRC_RX_CMOS = 4'hE,
    SGP_SRC_RX_COMPARATOR = 4'hF
  } sgp_src_t;

  typedef logic [8:0] sgp_reg_t;

endpackage : sgp_pkg

/* File: sgp_rx_if.sv */
// sgp_rx_if.sv: carries received data words to the non-pcm sync detector
// and its flag back. assumes both ends run on the same core clock.
interface sgp_rx_if;
  logic word_valid;
  logic [15:0] word;
  logic clear;
  logic pcm_n;

  modport det (input word_valid, input word, input clear, output pcm_n);
  modport ctl (output word_valid, output word, output clear, input pcm_n);
endinterface : sgp_rx_if

/* File: sgp_nonpcm_detect.sv */
// sgp_nonpcm_detect.sv: searches the received data words for the non-audio
// sync code and holds the non-pcm flag. assumes one word per valid strobe.
module sgp_nonpcm_detect
  import sgp_pkg::*;
#(
  parameter int HOLD_WORDS = `SGP_PCM_HOLD_WORDS
) (
  input wire logic core_clk,
  input wire logic arst_n,
  sgp_rx_if.det rx
);

  localparam int CW = $clog2(HOLD_WORDS + 1);

  if (HOLD_WORDS < 1) begin : g_bad_hold
    $error("sgp_nonpcm_detect: HOLD_WORDS must be at least 1");
  end

  logic [95:0] shift_r;
  logic [CW-1:0] gap_r;
  logic pcm_n_r;
  logic [95:0] shift_nxt;
  logic match;
  logic gap_done;

  // compare on the word just arriving, so the flag rises with the last sync word
  assign shift_nxt = {shift_r[79:0], rx.word};
  assign match = rx.word_valid && (shift_nxt == `SGP_SYNC_CODE);
  assign gap_done = (gap_r == CW'(HOLD_WORDS - 1));
  assign rx.pcm_n = pcm_n_r;

  // shift in words; the flag drops after a long run of words without a burst, or at once on clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_r <= '0;
      gap_r <= '0;
      pcm_n_r <= 1'b0;
    end else if (rx.clear) begin
      shift_r <= '0;
      gap_r <= '0;
      pcm_n_r <= 1'b0;
    end else if (rx.word_valid) begin
      shift_r <= shift_nxt;
      if (match) begin
        gap_r <= '0;
        pcm_n_r <= 1'b1;
      end else if (gap_done) begin
        gap_r <= '0;
        pcm_n_r <= 1'b0;
      end else begin
        gap_r <= gap_r + 1'b1;
      end
    end
  end

endmodule : sgp_nonpcm_detect

/* File: sgp_status_ctrl_monitor.sv */
// sgp_status_ctrl_monitor.sv: port assertions for the status control block.
// assumes one core_clk domain; bound onto every sgp_status_ctrl instance.
`include "sgp_defines.svh"
module sgp_status_ctrl_monitor
  import sgp_pkg::*;
#(
  parameter int NUM_PINS = 7
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [6:0] reg_addr,
  input wire logic [8:0] reg_wdata,
  input wire logic reg_rvalid,
  input wire logic rx_audio_n,
  input wire logic first_stereo_dac_from_rx,
  input wire logic nonaudio_change_event,
  input wire logic interrupt_out_low,
  input wire logic first_stereo_dac_softmute,
  input wire logic [NUM_PINS-1:0] gpo_pin_oe,
  input wire logic adc_off,
  input wire logic [2:0] dac_off,
  input wire logic link_tx_off,
  input wire logic link_rx_off,
  input wire logic clock_recovery_off,
  input wire logic first_pll_off,
  input wire logic second_pll_off,
  input wire logic oscillator_off,
  input wire logic osc_ext_clk_mode,
  input wire logic references_off,
  input wire logic outputs_muted
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  // write data two cycles back: the derived outputs settle that late
  logic [8:0] wd1_r;
  logic [8:0] wd2_r;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wd1_r <= 9'h000;
      wd2_r <= 9'h000;
    end else begin
      wd1_r <= reg_wdata;
      wd2_r <= wd1_r;
    end
  end

  // powerdown register writes
  wire wr_conv = reg_wr_en && reg_addr == `SGP_OFS_PWR_CONV;
  wire wr_clk = reg_wr_en && reg_addr == `SGP_OFS_PWR_CLK;

  sequence s_conv_done;
    wr_conv ##1 1'b1;
  endsequence
  sequence s_clk_done;
    wr_clk ##1 1'b1;
  endsequence

  property p_adc;
    s_conv_done |=> adc_off == (wd2_r[1] | wd2_r[0]);
  endproperty
  a_adc: assert property (p_adc) else $error("adc powerdown differs from write");
  property p_dac;
    s_conv_done |=> dac_off == ((wd2_r[6] | wd2_r[0]) ? 3'h7 : wd2_r[4:2]);
  endproperty
  a_dac: assert property (p_dac) else $error("dac powerdown differs from write");
  property p_refs;
    s_conv_done |=> references_off == wd2_r[0] && outputs_muted == wd2_r[0];
  endproperty
  a_refs: assert property (p_refs) else $error("master powerdown not applied");
  // master powerdown may force the clock bits, so only the clear case is exact
  property p_clk;
    s_clk_done |=> references_off || {link_rx_off, link_tx_off, clock_recovery_off,
      second_pll_off, first_pll_off, oscillator_off} == wd2_r[5:0];
  endproperty
  a_clk: assert property (p_clk) else $error("clock powerdown differs from write");
  property p_osc;
    osc_ext_clk_mode == oscillator_off;
  endproperty
  a_osc: assert property (p_osc) else $error("external clock mode mismatch");
  property p_oe;
    $past(arst_n) |-> gpo_pin_oe[1:0] == 2'h3 && gpo_pin_oe[NUM_PINS-1:5] == 2'h3;
  endproperty
  a_oe: assert property (p_oe) else $error("output-only pin released");
  property p_mute;
    first_stereo_dac_from_rx && rx_audio_n |=> first_stereo_dac_softmute;
  endproperty
  a_mute: assert property (p_mute) else $error("first dac not muted");
  property p_unmute;
    !first_stereo_dac_from_rx |=> !first_stereo_dac_softmute;
  endproperty
  a_unmute: assert property (p_unmute) else $error("mute held off receiver");
  property p_evt;
    nonaudio_change_event |-> !interrupt_out_low;
  endproperty
  a_evt: assert property (p_evt) else $error("event without interrupt");
  property p_rd;
    reg_rd_en |=> reg_rvalid;
  endproperty
  a_rd: assert property (p_rd) else $error("read not answered");
endmodule : sgp_status_ctrl_monitor

bind sgp_status_ctrl sgp_status_ctrl_monitor #(.NUM_PINS(NUM_PINS)) u_mon (.core_clk, .arst_n,
  .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rvalid, .rx_audio_n, .first_stereo_dac_from_rx,
  .nonaudio_change_event, .interrupt_out_low, .first_stereo_dac_softmute, .gpo_pin_oe, .adc_off,
  .dac_off, .link_tx_off, .link_rx_off, .clock_recovery_off, .first_pll_off, .second_pll_off,
  .oscillator_off, .osc_ext_clk_mode, .references_off, .outputs_muted);

/* File: tb_sgp_status_ctrl.sv */
// tb_sgp_status_ctrl.sv: directed register, pin and non-audio tests.
// assumes a short sync hold count so the flag release stays quick.
`include "sgp_defines.svh"
module tb_sgp_status_ctrl
  import sgp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [8:0] reg_wdata = 9'h000;
  logic rx_word_valid = 1'b0;
  logic [15:0] rx_word = 16'h0000;
  logic [13:1] src = 13'h0000;
  logic first_stereo_dac_from_rx = 1'b0;
  logic irq_ack = 1'b0;
  logic [6:0] gpo_pin_in = 7'h00;
  logic [8:0] reg_rdata;
  logic reg_rvalid, rx_pcm_n, ev, irq_n, mute;
  logic [6:0] gpo_pin_out, gpo_pin_oe;
  logic [2:0] rx_cmos_in_sel, rx_comp_in_sel, rx_pin_data, dac_off;
  logic adc_off, link_tx_off, link_rx_off, clock_recovery_off, first_pll_off, second_pll_off;
  logic oscillator_off, osc_ext_clk_mode, references_off, outputs_muted;
  int fail_count = 0;
  int cmp_count = 0;
  int ev_cnt = 0;
  wire [8:0] pd1 = {2'h0, oscillator_off, outputs_muted, references_off, adc_off, dac_off};
  wire [8:0] pd2 = {2'h0, osc_ext_clk_mode, link_rx_off, link_tx_off, clock_recovery_off,
    second_pll_off, first_pll_off, oscillator_off};
  logic [6:0] ra [7] = '{7'h25, 7'h26, 7'h27, 7'h28, 7'h29, 7'h32, 7'h33};
  logic [8:0] rv [7] = '{`SGP_RST_INT_MASK, `SGP_RST_GPO_12, `SGP_RST_GPO_34, `SGP_RST_GPO_56,
    `SGP_RST_GPO_7, `SGP_RST_PWR_CONV, `SGP_RST_PWR_CLK};
  // converter register writes and the powerdown outputs each one should give
  logic [8:0] pw [5] = '{9'h000, 9'h014, 9'h002, 9'h040, 9'h054};
  logic [8:0] pe [5] = '{9'h000, 9'h005, 9'h008, 9'h007, 9'h007};
  logic fill_zero, ignore_inv;

  sgp_status_ctrl #(.HOLD_WORDS(8), .NUM_PINS(7)) u_dut (.core_clk, .arst_n, .reg_wr_en,
    .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid, .rx_word_valid, .rx_word,
    .rx_validity(src[1]), .rx_user(src[2]), .rx_channel(src[3]), .rx_parity(src[4]),
    .subframe_indicator(src[5]), .block_start_indicator(src[6]), .rx_unlock(src[7]),
    .chan_status_update(src[8]), .rate_is_top_flag(src[9]), .zero_detect_flag(src[10]),
    .rx_audio_n(src[11]), .copy_assert_low(src[12]), .emphasis_flag(src[13]), .first_stereo_dac_from_rx,
    .irq_other_n(1'b1), .irq_ack, .rx_pcm_n, .nonaudio_change_event(ev), .interrupt_out_low(irq_n),
    .first_stereo_dac_softmute(mute), .fill_zero_mode(fill_zero), .ignore_invalid(ignore_inv), .gpo_pin_in,
    .gpo_pin_out, .gpo_pin_oe, .rx_cmos_in_sel, .rx_comp_in_sel, .rx_pin_data, .adc_off, .dac_off,
    .link_tx_off, .link_rx_off, .clock_recovery_off, .first_pll_off, .second_pll_off,
    .oscillator_off, .osc_ext_clk_mode, .references_off, .outputs_muted);

  always #4 core_clk = ~core_clk;
  // events last one cycle, so one falling edge sees each
  always @(negedge core_clk) if (ev === 1'b1) ev_cnt++;

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // each access waits a falling edge first, so strobes never toggle twice at once
  task automatic wr(input logic [6:0] a, input logic [8:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic [8:0] e);
    int n = 0;
    @(negedge core_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge core_clk);
    reg_rd_en = 1'b0;
    while (reg_rvalid !== 1'b1 && n < 4) begin
      @(negedge core_clk);
      n++;
    end
    chk(reg_rdata, e);
  endtask : rd
  // six words back to back, oldest first
  task automatic send(input logic [95:0] c);
    @(negedge core_clk);
    for (int i = 5; i >= 0; i--) begin
      rx_word = c[i*16 +: 16];
      rx_word_valid = 1'b1;
      @(negedge core_clk);
    end
    rx_word_valid = 1'b0;
  endtask : send
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  // about 300 cycles of tests, so 25000 cycles means a hang
  initial begin
    #200us;
    fail_count++;
    final_report();
  end

  initial begin
    repeat (10) @(negedge core_clk);
    arst_n = 1'b1;
    for (int i = 0; i < 7; i++) rd(ra[i], rv[i]);
    rd(7'h30, 9'h000);
    chk(pd1, 9'h00F);
    chk(pd2, 9'h03E);
    chk({gpo_pin_oe, gpo_pin_out[0]}, 9'h0FF);
    chk({fill_zero, ignore_inv}, 9'h000);
    $display("test reset done");
    // converters off before the master bit
    wr(7'h32, 9'h05E);
    wr(7'h32, 9'h05F);
    @(negedge core_clk);
    chk(pd1, 9'h07F);
    chk(pd2, 9'h07F);
    for (int i = 0; i < 5; i++) begin
      wr(7'h32, pw[i]);
      @(negedge core_clk);
      chk(pd1, pe[i]);
    end
    for (int i = 0; i < 6; i++) begin
      wr(7'h33, 9'(1 << i));
      @(negedge core_clk);
      chk(pd2, 9'(1 << i) | (i == 0 ? 9'h040 : 9'h000));
    end
    wr(7'h33, 9'h1FF);
    rd(7'h33, 9'h03F);
    wr(7'h30, 9'h1FF);
    rd(7'h30, 9'h000);
    rd(7'h32, 9'h054);
    $display("test powerdown done");
    // all seven pins on one code, so every selector field is exercised
    for (int c = 1; c < 14; c++) begin
      wr(7'h26, {1'b0, 4'(c), 4'(c)});
      wr(7'h27, {1'b0, 4'(c), 4'(c)});
      wr(7'h28, {1'b0, 4'(c), 4'(c)});
      wr(7'h29, {5'h00, 4'(c)});
      @(negedge core_clk);
      chk(gpo_pin_out, 9'h000);
      src[c] = 1'b1;
      @(negedge core_clk);
      chk(gpo_pin_out, 9'h07F);
      src[c] = 1'b0;
    end
    wr(7'h26, 9'h1FE);
    wr(7'h29, 9'h00F);
    wr(7'h27, 9'h1FE);
    wr(7'h28, 9'h05E);
    @(negedge core_clk);
    chk({gpo_pin_oe[6], gpo_pin_out[6], gpo_pin_oe[1:0], gpo_pin_out[1:0]}, 9'h02C);
    chk({gpo_pin_oe[4:2], rx_cmos_in_sel, rx_comp_in_sel}, 9'h02A);
    chk({fill_zero, ignore_inv}, 9'h003);
    gpo_pin_in = 7'h1C;
    repeat (3) @(negedge core_clk);
    chk(rx_pin_data, 9'h007);
    $display("test pins done");
    // the audio flag pulse in the pin test gave two events; ack them and power the receiver up
    chk(ev_cnt, 9'h002);
    irq_ack = 1'b1;
    wr(7'h33, 9'h000);
    irq_ack = 1'b0;
    ev_cnt = 0;
    first_stereo_dac_from_rx = 1'b1;
    send(96'h0000_0000_0000_0000_F872_4E1F);
    repeat (3) @(negedge core_clk);
    chk({rx_pcm_n, mute, irq_n}, 9'h006);
    chk(ev_cnt, 9'h001);
    irq_ack = 1'b1;
    @(negedge core_clk);
    irq_ack = 1'b0;
    wr(7'h25, 9'h030);
    send(96'h0);
    send(96'h0);
    repeat (3) @(negedge core_clk);
    chk({rx_pcm_n, mute, irq_n}, 9'h001);
    src[11] = 1'b1;
    repeat (3) @(negedge core_clk);
    chk({mute, irq_n}, 9'h003);
    chk(ev_cnt, 9'h001);
    wr(7'h25, 9'h000);
    src[11] = 1'b0;
    repeat (3) @(negedge core_clk);
    chk({mute, irq_n}, 9'h000);
    first_stereo_dac_from_rx = 1'b0;
    src[11] = 1'b1;
    repeat (3) @(negedge core_clk);
    chk({mute, 7'(ev_cnt)}, 9'h003);
    $display("test non-audio done");
    // reset in mid-run must restore the powerdown defaults over written values
    arst_n = 1'b0;
    repeat (2) @(negedge core_clk);
    arst_n = 1'b1;
    rd(7'h32, `SGP_RST_PWR_CONV);
    chk(pd1, 9'h00F);
    chk(pd2, 9'h03E);
    $display("test second reset done");
    final_report();
  end
endmodule : tb_sgp_status_ctrl
